// ---- hw/flash_host_pkg.sv ----
// shared constants and carrier types for the flash host controller
// assumes a 10 MHz clock; all other files refer to names here with pkg:: scope
package flash_host_pkg;

  // operations the user side may request
  typedef enum logic [2:0] {
    OP_READ, OP_ID_CMD, OP_ID_PIN, OP_PROGRAM, OP_ERASE, OP_RESET
  } op_e;

  // command codes written into the device command register, and the erased byte value
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // identifier addresses in command-driven identifier mode, and the zero address for command writes
  localparam logic [15:0] ID_MAKER_ADDR = 16'h0000;
  localparam logic [15:0] ID_PART_ADDR = 16'h0001;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;

  // timing: figures in their own unit, cycles derived from the clock period except the fixed strobe-low count WE_LOW_CYCLES
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACCESS_NS = 170;
  localparam int PROGRAM_WAIT_US = 10;
  localparam int VERIFY_WAIT_US = 6;
  localparam int ERASE_WAIT_MS = 10;
  localparam int VPP_RAMP_US = 2;
  localparam logic [2:0] ACCESS_CYCLES = 3'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] WE_LOW_CYCLES = 3'h2;
  localparam int TIMER_W = 17;
  localparam logic [TIMER_W-1:0] PROGRAM_WAIT_CYCLES =
    TIMER_W'((PROGRAM_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] VERIFY_WAIT_CYCLES =
    TIMER_W'((VERIFY_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] VPP_RAMP_CYCLES =
    TIMER_W'((VPP_RAMP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int ERASE_WAIT_CYCLES = (ERASE_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // user request
  typedef struct packed {
    op_e op;
    logic [15:0] addr;
    logic [7:0] data;
  } flash_req_s;

  // one bus cycle handed to the cycle engine
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [7:0] data;
  } cycle_req_s;

  // strobes and address toward the device
  typedef struct packed {
    logic chipSelectN;
    logic outputGateN;
    logic writeStrobeN;
    logic [15:0] addr;
  } flash_pins_s;

endpackage

// ---- hw/flash_bus_cycle.sv ----
// single read or write bus cycle on the flash strobes
// assumes the caller holds req stable from start until done
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // cycle request
  input wire logic start,
  input wire flash_host_pkg::cycle_req_s req,
  output logic done,
  output logic [7:0] readData,
  // flash pins
  output flash_host_pkg::flash_pins_s pins,
  input wire logic [7:0] byteBusIn,
  output logic [7:0] byteBusOut,
  output logic byteBusOe
);

  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} cycle_state_e;
  cycle_state_e state;
  logic [2:0] cnt;
  logic isWrite;
  wire waitOver = (cnt == 3'h0);

  // cycle sequencer; strobes and data come straight from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= CY_IDLE;
      pins <= '{chipSelectN: 1'b1, outputGateN: 1'b1, writeStrobeN: 1'b1, addr: 16'h0000};
      byteBusOut <= 8'h00;
      byteBusOe <= 1'b0;
      done <= 1'b0;
      readData <= 8'h00;
      cnt <= 3'h0;
      isWrite <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!waitOver) cnt <= 3'(cnt - 3'h1);
      case (state)
        CY_IDLE: if (start) begin
          pins.addr <= req.addr;
          pins.chipSelectN <= 1'b0;
          // read with gate low and write strobe high
          pins.outputGateN <= req.write;
          isWrite <= req.write;
          byteBusOut <= req.data;
          byteBusOe <= req.write;
          cnt <= req.write ? 3'h0 : flash_host_pkg::ACCESS_CYCLES;
          state <= CY_SETUP;
        end
        CY_SETUP: if (waitOver) begin
          if (isWrite) begin
            // address latched on this falling edge
            pins.writeStrobeN <= 1'b0;
            cnt <= 3'(flash_host_pkg::WE_LOW_CYCLES - 3'h1);
            state <= CY_STROBE;
          end else begin
            readData <= byteBusIn;
            pins.chipSelectN <= 1'b1;
            pins.outputGateN <= 1'b1;
            done <= 1'b1;
            state <= CY_IDLE;
          end
        end
        CY_STROBE: if (waitOver) begin
          // data latched on this rising edge, still driven
          pins.writeStrobeN <= 1'b1;
          state <= CY_HOLD;
        end
        CY_HOLD: begin
          pins.chipSelectN <= 1'b1;
          byteBusOe <= 1'b0;
          done <= 1'b1;
          state <= CY_IDLE;
        end
        default: state <= CY_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // strobe only with chip selected, gate high and data driven
  a_strobe_select: assert property (
    !pins.writeStrobeN |-> !pins.chipSelectN && pins.outputGateN && byteBusOe)
    else $error("write strobe low without select, gate high and data");
  // no host drive while the device may drive the bus
  a_read_no_drive: assert property (
    !pins.outputGateN |-> !byteBusOe && pins.writeStrobeN && !pins.chipSelectN)
    else $error("host drives bus during read");
  // address and data hold across the strobe rising edge
  a_latch_stable: assert property (
    $rose(pins.writeStrobeN) |-> $stable(byteBusOut) && $stable(pins.addr) && byteBusOe)
    else $error("data or address moved at strobe rise");

endmodule
`default_nettype wire

// ---- hw/flash_host_ctrl.sv ----
// host-side controller that runs read, identify, program, erase and reset
// sequences on a parallel flash through its strobes, address and byte bus
// assumes inputs synchronous to clk and one request at a time
//
// Contract
// - reads drive select and gate low, write strobe high.
// - identifier by high voltage on address bit nine, other bits low.
// - erased array reads ones; user preprograms zeros before erasing.
// - write pulses strobe low with select low; address then data latched.
// - erase is 20h written twice; erase starts on second write.
// - host waits at least 10 ms before erase-verify A0h.
// - host verifies bytes after erase; non-FFh means erase again; code checks one byte and only flags it.
// - program is 40h then a write with target address and byte.
// - after program, C0h then a read returns programmed byte.
// - FFh twice aborts set-up and returns to read mode.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl #(
  parameter int ERASE_WAIT_CYCLES = flash_host_pkg::ERASE_WAIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user request
  input wire logic reqValid,
  output logic reqReady,
  input wire flash_host_pkg::flash_req_s req,
  // user response
  output logic respValid,
  output logic [7:0] respData,
  output logic respMismatch,
  // flash strobes, address and byte bus
  output flash_host_pkg::flash_pins_s pins,
  input wire logic [7:0] byteBusIn,
  output logic [7:0] byteBusOut,
  output logic byteBusOe,
  // supply and identifier voltage controls
  output logic vppHigh,
  output logic idHighVoltage
);

  typedef enum logic [3:0] {
    S_IDLE, S_VPP, S_CMD1, S_CMD2, S_WAIT, S_VERIFY, S_VWAIT, S_READ, S_RESTORE, S_DONE
  } ctrl_state_e;

  localparam int TW = flash_host_pkg::TIMER_W;

  ctrl_state_e state;
  flash_host_pkg::flash_req_s cur;
  logic [TW-1:0] timer;
  logic issued;
  logic cycDone;
  logic [7:0] cycRead;
  flash_host_pkg::cycle_req_s cycReq;

  // operation decode
  wire isProgram = (cur.op == flash_host_pkg::OP_PROGRAM);
  wire isErase = (cur.op == flash_host_pkg::OP_ERASE);
  wire isIdCmd = (cur.op == flash_host_pkg::OP_ID_CMD);
  wire isIdPin = (cur.op == flash_host_pkg::OP_ID_PIN);
  wire isReset = (cur.op == flash_host_pkg::OP_RESET);
  wire reqNeedsVpp = (req.op != flash_host_pkg::OP_READ) && (req.op != flash_host_pkg::OP_ID_PIN);
  wire timerDone = (timer == '0);
  wire cycleState = (state == S_CMD1) || (state == S_CMD2) || (state == S_VERIFY) ||
                    (state == S_READ) || (state == S_RESTORE);
  wire startCycle = cycleState && !issued;
  wire stepDone = cycleState && cycDone;
  wire [TW-1:0] eraseWait = TW'(ERASE_WAIT_CYCLES);

  // first command byte of each two-write sequence
  wire [7:0] firstCmd = isProgram ? flash_host_pkg::CMD_PROGRAM :
                        isErase ? flash_host_pkg::CMD_ERASE :
                        isIdCmd ? flash_host_pkg::CMD_IDENT :
                        isReset ? flash_host_pkg::CMD_RESET : flash_host_pkg::CMD_READ;
  // second write: program carries address and byte, erase and reset repeat
  wire [7:0] secondCmd = isProgram ? cur.data : firstCmd;
  wire [15:0] secondAddr = isProgram ? cur.addr : flash_host_pkg::ADDR_ZERO;
  // verify command: erase-verify latches the byte address, program-verify none
  wire [7:0] verifyCmd = isErase ? flash_host_pkg::CMD_ERASE_VERIFY :
                         flash_host_pkg::CMD_PROGRAM_VERIFY;
  wire [15:0] verifyAddr = isErase ? cur.addr : flash_host_pkg::ADDR_ZERO;
  // read address: identifier modes select only by bit zero
  wire [15:0] idCmdAddr = cur.addr[0] ? flash_host_pkg::ID_PART_ADDR :
                          flash_host_pkg::ID_MAKER_ADDR;
  wire [15:0] readAddr = isIdCmd ? idCmdAddr :
                         isIdPin ? {15'h0000, cur.addr[0]} : cur.addr;
  // expected readback and compare result
  // erased array reads all ones
  wire [7:0] expected = isErase ? flash_host_pkg::ERASED_BYTE : cur.data;
  wire readMismatch = (isErase || isProgram) && (cycRead != expected);

  // bus cycle selection per state
  assign cycReq.write = (state != S_READ);
  assign cycReq.addr = (state == S_CMD2) ? secondAddr :
                       (state == S_VERIFY) ? verifyAddr :
                       (state == S_READ) ? readAddr : flash_host_pkg::ADDR_ZERO;
  assign cycReq.data = (state == S_CMD1) ? firstCmd :
                       (state == S_CMD2) ? secondCmd :
                       (state == S_VERIFY) ? verifyCmd : flash_host_pkg::CMD_READ;
  assign reqReady = (state == S_IDLE);

  flash_bus_cycle u_cycle (
    .clk(clk),
    .rst(rst),
    .start(startCycle),
    .req(cycReq),
    .done(cycDone),
    .readData(cycRead),
    .pins(pins),
    .byteBusIn(byteBusIn),
    .byteBusOut(byteBusOut),
    .byteBusOe(byteBusOe)
  );

  // cycle issue tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) issued <= 1'b0;
    else if (stepDone) issued <= 1'b0;
    else if (startCycle) issued <= 1'b1;
  end

  // sequence state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      cur <= '{op: flash_host_pkg::OP_READ, addr: 16'h0000, data: 8'h00};
      timer <= '0;
      vppHigh <= 1'b0;
      idHighVoltage <= 1'b0;
      respValid <= 1'b0;
      respData <= 8'h00;
      respMismatch <= 1'b0;
    end else begin
      respValid <= 1'b0;
      if (!timerDone) timer <= TW'(timer - 1'b1);
      case (state)
        S_IDLE: if (reqValid) begin
          cur <= req;
          respMismatch <= 1'b0;
          // raise the supply and let it ramp before any write
          vppHigh <= reqNeedsVpp;
          // identifier by high voltage with supply left low
          idHighVoltage <= (req.op == flash_host_pkg::OP_ID_PIN);
          timer <= flash_host_pkg::VPP_RAMP_CYCLES;
          // plain reads go straight out, supply low
          state <= (req.op == flash_host_pkg::OP_READ) ? S_READ : S_VPP;
        end
        S_VPP: if (timerDone) state <= isIdPin ? S_READ : S_CMD1;
        S_CMD1: if (stepDone) state <= isIdCmd ? S_READ : S_CMD2;
        S_CMD2: if (stepDone) begin
          // second erase write starts the erase
          // second program write carries address and byte
          // second reset write ends the sequence
          timer <= isErase ? eraseWait : flash_host_pkg::PROGRAM_WAIT_CYCLES;
          state <= isReset ? S_DONE : S_WAIT;
        end
        // erase or program time before the verify command
        S_WAIT: if (timerDone) state <= S_VERIFY;
        S_VERIFY: if (stepDone) begin
          // this strobe rise ends the erase
          timer <= flash_host_pkg::VERIFY_WAIT_CYCLES;
          state <= S_VWAIT;
        end
        S_VWAIT: if (timerDone) state <= S_READ;
        S_READ: if (stepDone) begin
          respData <= cycRead;
          // erase readback checked against all ones
          // program readback checked against written byte
          respMismatch <= readMismatch;
          state <= (isIdCmd || isProgram || isErase) ? S_RESTORE : S_DONE;
        end
        S_RESTORE: if (stepDone) state <= S_DONE;
        S_DONE: begin
          vppHigh <= 1'b0;
          idHighVoltage <= 1'b0;
          respValid <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // helpers seen only by the checks below
  logic [7:0] lastWritten;
  logic [TW:0] gapCount;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastWritten <= 8'h00;
      gapCount <= '0;
    end else begin
      if ($rose(pins.writeStrobeN)) lastWritten <= byteBusOut;
      if ($rose(pins.writeStrobeN)) gapCount <= '0;
      else if (!gapCount[TW]) gapCount <= (TW+1)'(gapCount + 1'b1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence verifyIssued;
    state == S_VERIFY && cycDone;
  endsequence
  sequence settleWait;
    (state == S_VWAIT && pins.chipSelectN)[*8];
  endsequence

  a_vpp_on_write: assert property (
    !pins.writeStrobeN |-> vppHigh && !idHighVoltage)
    else $error("write strobe without programming supply");
  a_id_pin_addr: assert property (
    idHighVoltage && !pins.outputGateN |-> pins.addr[15:1] == 15'h0000 && !vppHigh)
    else $error("identifier read with upper address bits set");
  a_erase_twice: assert property (
    $rose(pins.writeStrobeN) && state == S_CMD2 && isErase |->
      lastWritten == flash_host_pkg::CMD_ERASE && byteBusOut == flash_host_pkg::CMD_ERASE)
    else $error("erase not preceded by set-up erase");
  a_reset_pair: assert property (
    $rose(pins.writeStrobeN) && state == S_CMD2 && isReset |->
      lastWritten == flash_host_pkg::CMD_RESET && byteBusOut == flash_host_pkg::CMD_RESET)
    else $error("reset not written twice");
  a_erase_gap: assert property (
    $fell(pins.writeStrobeN) && state == S_VERIFY && isErase |->
      gapCount >= (TW+1)'(ERASE_WAIT_CYCLES))
    else $error("erase-verify written too early");
  a_verify_settle: assert property (
    verifyIssued |=> settleWait)
    else $error("readback not delayed after verify command");
  a_erased_compare: assert property (
    respValid && isErase |-> respMismatch == (respData != flash_host_pkg::ERASED_BYTE))
    else $error("erase result does not match readback");
  a_prog_second: assert property (
    $fell(pins.writeStrobeN) && state == S_CMD2 && isProgram |->
      pins.addr == cur.addr && byteBusOut == cur.data ##1 !pins.writeStrobeN)
    else $error("program write lacks target address or byte");

endmodule
`default_nettype wire

// ---- bench/flash_device_model.sv ----
// behavioural model of the parallel flash seen by the host controller
// assumes the bench resolves the byte bus from the host's enable alone
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
  parameter realtime ERASE_MIN_NS = 20000.0,
  parameter realtime ERASE_STOP_NS = 100000.0,
  parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary identifier value
  parameter logic [7:0] PART_CODE = 8'h3C // arbitrary identifier value
) (
  // host strobes, address and data
  input wire flash_host_pkg::flash_pins_s pins,
  input wire logic [7:0] hostData,
  input wire logic vppHigh,
  input wire logic idHighVoltage,
  // device drive of the byte bus
  output logic [7:0] devData,
  output logic devOe,
  // host rule breaches seen
  output var int hostFaults
);
  localparam logic [7:0] IDLE_MODE = 8'h01; // inactive after a program pulse
  logic [7:0] mem [0:65535];
  logic [7:0] cmd, prevCmd, lastOut, readByte;
  logic [15:0] latchAddr, verifyAddr, progAddr;
  logic erasing;
  realtime eraseStart;
  wire reading = !pins.chipSelectN && !pins.outputGateN && pins.writeStrobeN;

  // array erased, read command at power-up
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    cmd = 8'h00;
    erasing = 1'b0;
    hostFaults = 0;
    lastOut = 8'h00;
  end

  // address on falling edge; write needs supply high and gate high
  always @(negedge pins.writeStrobeN) begin
    if (!pins.chipSelectN) begin
      latchAddr = pins.addr;
      if (!vppHigh || !pins.outputGateN) hostFaults++;
    end
  end

  // other address bits low while identifier voltage applied
  always @(negedge pins.outputGateN) begin
    if (idHighVoltage && pins.addr[15:1] != 15'h0000) hostFaults++;
  end

  // data taken on rising edge, only with supply high
  always @(posedge pins.writeStrobeN) begin
    if (!pins.chipSelectN && vppHigh) begin
      prevCmd = cmd;
      if (erasing) begin
        // next write ends the erase; too early leaves it undone
        erasing = 1'b0;
        verifyAddr = latchAddr;
        if ($realtime - eraseStart < ERASE_MIN_NS) hostFaults++;
        else foreach (mem[i]) mem[i] = 8'hFF;
        cmd = hostData;
      end else if (prevCmd == 8'h40) begin
        // program clears bits at the latched address, any data byte
        mem[latchAddr] = mem[latchAddr] & hostData;
        progAddr = latchAddr;
        // an all-ones byte changes nothing and counts as a first reset
        cmd = (hostData == 8'hFF) ? 8'hFF : IDLE_MODE;
      end else if (hostData == 8'hFF) begin
        cmd = (prevCmd == 8'hFF) ? 8'h00 : 8'hFF;
      end else if (prevCmd == 8'h20 && hostData == 8'h20) begin
        // erase starts on the second code
        erasing = 1'b1;
        eraseStart = $realtime;
        cmd = hostData;
      end else begin
        // verify address kept until next command
        if (hostData == 8'hA0) verifyAddr = latchAddr;
        cmd = hostData;
      end
    end
  end

  // stop timer ends an erase left running; device then idles
  always @(posedge erasing) begin
    #(ERASE_STOP_NS);
    if (erasing && $realtime - eraseStart >= ERASE_STOP_NS) begin
      erasing = 1'b0;
      foreach (mem[i]) mem[i] = 8'hFF;
      cmd = IDLE_MODE;
    end
  end

  // read source by mode, supply level irrelevant
  assign readByte = idHighVoltage ? (pins.addr[0] ? PART_CODE : MAKER_CODE) :
    (cmd == 8'h90) ? (pins.addr == 16'h0001 ? PART_CODE :
    (pins.addr == 16'h0000 ? MAKER_CODE : 8'h00)) :
    (cmd == 8'hA0) ? mem[verifyAddr] :
    (cmd == 8'hC0) ? mem[progAddr] : mem[pins.addr];

  // drive only when selected and gated; released bus shows inverse
  always @* if (reading) lastOut = readByte;
  assign devOe = reading;
  assign devData = reading ? readByte : ~lastOut;
endmodule
`default_nettype wire

// ---- bench/test_flash_host_ctrl.sv ----
// self-checking bench for the flash host controller against the device model
// assumes a 10 MHz clock and a shortened erase wait
`timescale 1ns/1ps
`default_nettype none
module test_flash_host_ctrl;
  localparam int ERASE_CYC = 200;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary identifier value
  localparam logic [7:0] PART = 8'h3C; // arbitrary identifier value
  logic clk, rst, reqValid, reqReady, respValid, respMismatch;
  logic byteBusOe, vppHigh, idHighVoltage, devOe;
  logic [7:0] respData, byteBusOut, byteBusIn, devData, lastData;
  flash_host_pkg::flash_req_s req;
  flash_host_pkg::flash_pins_s pins;
  int hostFaults, failCount, checksDone;
  logic [31:0] rngState;
  logic [7:0] refMem [0:65535];
  flash_host_pkg::op_e ops [5] = '{flash_host_pkg::OP_READ, flash_host_pkg::OP_ID_CMD,
    flash_host_pkg::OP_ID_PIN, flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_RESET};

  // byte bus wire: host drive wins, else the model's value
  assign byteBusIn = byteBusOe ? byteBusOut : devData;

  flash_host_ctrl #(.ERASE_WAIT_CYCLES(ERASE_CYC)) u_dut (.clk(clk), .rst(rst),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .respValid(respValid),
    .respData(respData), .respMismatch(respMismatch), .pins(pins), .byteBusIn(byteBusIn),
    .byteBusOut(byteBusOut), .byteBusOe(byteBusOe), .vppHigh(vppHigh),
    .idHighVoltage(idHighVoltage));
  flash_device_model #(.ERASE_MIN_NS(ERASE_CYC * 100.0), .MAKER_CODE(MAKER),
    .PART_CODE(PART)) u_dev (.pins(pins), .hostData(byteBusOut), .vppHigh(vppHigh),
    .idHighVoltage(idHighVoltage), .devData(devData), .devOe(devOe),
    .hostFaults(hostFaults));

  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // xorshift source
  function automatic logic [31:0] nextRand();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction

  // expected {mismatch, data} for one operation; tracks the array copy
  function automatic logic [8:0] expectResp(flash_host_pkg::op_e op, logic [15:0] a,
                                            logic [7:0] d);
    logic [8:0] r;
    case (op)
      flash_host_pkg::OP_READ: r = {1'b0, refMem[a]};
      flash_host_pkg::OP_ID_CMD, flash_host_pkg::OP_ID_PIN: r = {1'b0, a[0] ? PART : MAKER};
      flash_host_pkg::OP_PROGRAM: begin
        refMem[a] = refMem[a] & d;
        r = {refMem[a] !== d, refMem[a]};
      end
      flash_host_pkg::OP_ERASE: begin
        foreach (refMem[i]) refMem[i] = 8'hFF;
        r = {1'b0, 8'hFF};
      end
      default: r = {1'b0, lastData};
    endcase
    lastData = r[7:0];
    return r;
  endfunction

  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp, input string what);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic timedOut(input string what);
    failCount++;
    $display("[ERR] %0t wait for %s ran out", $time, what);
    giveVerdict();
  endtask

  // one request, waits bounded for the answer and compares it
  task automatic runOp(input flash_host_pkg::op_e op, input logic [15:0] a,
                       input logic [7:0] d);
    logic [8:0] e;
    int n;
    @(posedge clk);
    #1;
    reqValid = 1'b1;
    req = '{op: op, addr: a, data: d};
    n = 0;
    do begin @(negedge clk); n++; end while (reqReady !== 1'b1 && n < 50);
    if (n >= 50) timedOut("ready");
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    e = expectResp(op, a, d);
    n = 0;
    do begin @(negedge clk); n++; end while (respValid !== 1'b1 && n < 3000);
    if (n >= 3000) timedOut("response");
    checkByte(respData, e[7:0], "response byte");
    checkBit(respMismatch, e[8], "verify flag");
    @(negedge clk);
    checkBit(respValid, 1'b0, "response pulse");
  endtask

  // no contention on the byte bus
  always @(negedge clk) begin
    if (!rst && byteBusOe && devOe) begin
      failCount++;
      $display("[ERR] %0t both parties drive the byte bus", $time);
    end
  end

  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    req = '0;
    rngState = 32'h0000D9AE;
    lastData = 8'h00;
    failCount = 0;
    checksDone = 0;
    foreach (refMem[i]) refMem[i] = 8'hFF;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    @(negedge clk);
    checkBit(pins.chipSelectN, 1'b1, "select idle");
    checkBit(pins.writeStrobeN, 1'b1, "strobe idle");
    checkBit(vppHigh, 1'b0, "supply idle");
    checkBit(reqReady, 1'b1, "ready idle");
    // corner cases: identifiers both ways, bit set refused, reset, erase
    runOp(flash_host_pkg::OP_READ, 16'hFFFF, 8'h00);
    runOp(flash_host_pkg::OP_ID_CMD, 16'h0000, 8'h00);
    runOp(flash_host_pkg::OP_ID_CMD, 16'h0001, 8'h00);
    runOp(flash_host_pkg::OP_ID_PIN, 16'h0000, 8'h00);
    runOp(flash_host_pkg::OP_ID_PIN, 16'h0001, 8'h00);
    runOp(flash_host_pkg::OP_PROGRAM, 16'h0000, 8'hA5);
    runOp(flash_host_pkg::OP_PROGRAM, 16'h0000, 8'h5A);
    runOp(flash_host_pkg::OP_READ, 16'h0000, 8'h00);
    runOp(flash_host_pkg::OP_RESET, 16'h0000, 8'h00);
    runOp(flash_host_pkg::OP_READ, 16'h0000, 8'h00);
    runOp(flash_host_pkg::OP_ERASE, 16'h1234, 8'h00);
    runOp(flash_host_pkg::OP_READ, 16'h0000, 8'h00);
    // random mix over a small address range so reads meet programmed bytes
    repeat (24) begin
      runOp(ops[nextRand() % 5], 16'(nextRand() % 16), 8'(nextRand() % 256));
    end
    checkByte(8'(hostFaults), 8'h00, "host breaches seen by device");
    giveVerdict();
  end
endmodule
`default_nettype wire
